// file: shared/coe_pkg.sv
// constants, types and carriers shared by the card output edit buffer
package coe_pkg;
   // ******************************
   // track geometry
   // ******************************
   localparam int NUM_POS = 316;
   localparam int POS_W = 9;
   localparam logic [8:0] POS_LAST = 9'h13B;
   localparam int NUM_TRACKS = 5;
   localparam int WORD_W = 44;
   localparam logic [3:0] DIG_LAST = 4'hA;
   localparam logic [4:0] WORD_LAST = 5'h1C;
   localparam int ADDR_W = 16;
   // ******************************
   // output shifter and card rows
   // ******************************
   localparam int SHIFT_LEN = 120;
   localparam int PUNCH_LEN = 80;
   localparam logic [3:0] ROW_FIRST = 4'h0;
   localparam logic [3:0] ROW_NUM_END = 4'h9;
   localparam logic [3:0] ROW_ZONE_11 = 4'hA;
   localparam logic [3:0] ROW_ZONE_12 = 4'hB;
   localparam logic [3:0] ROW_LAST = 4'hB;
   localparam logic [3:0] DIG_MINUS = 4'h1;
   localparam logic [3:0] DIG_PLUS = 4'h0;
   // ******************************
   // pattern digits
   // ******************************
   localparam logic [1:0] PAT_BLANK = 2'h0;
   localparam logic [1:0] PAT_ALPHA = 2'h1;
   localparam logic [1:0] PAT_NUMERIC = 2'h2;
   localparam logic [1:0] PAT_DELETE = 2'h3;
   localparam logic [2:0] TRACK_MIN = 3'h1;
   localparam logic [2:0] TRACK_MAX = 3'h5;
   // ******************************
   // types
   // ******************************
   typedef enum logic [0:0] {
      OP_WRITE = 1'b0,
      OP_PATLOAD = 1'b1
   } coe_op_t;
   typedef enum logic [1:0] {
      C_IDLE = 2'b00,
      C_FETCH = 2'b01,
      C_FILL = 2'b10
   } coe_cstate_t;
   typedef enum logic [1:0] {
      L_IDLE = 2'b00,
      L_SCAN = 2'b01,
      L_DRAIN = 2'b10,
      L_WAIT = 2'b11
   } coe_lstate_t;
   typedef struct packed {
      coe_op_t op;
      logic [2:0] track;
      logic suppress12;
      logic punch;
      logic [ADDR_W-1:0] addr;
   } coe_cmd_t;
   typedef struct packed {
      logic load;
      logic next;
      logic [ADDR_W-1:0] target;
   } coe_branch_t;
endpackage : coe_pkg

// file: hw/coe_sync.sv
// two-flop synchroniser, also used as reset release synchroniser
`timescale 1ns/1ps
module coe_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= d_i;
         sync_r <= meta_r;
      end
   end

   assign q_o = sync_r;
endmodule : coe_sync

// file: hw/coe_top.sv
// card output edit buffer: processor fill, pattern tracks, row scan to the card machine
//
// Operation
// - write moves 316 digits, 29 words, descending
// - pattern 0 inserts zero; store serial code
// - write while busy stalls the processor
// - readiness visible to the ready test
// - ready test loads target, else next
// - loaded track transfers to machine autonomously
// - latch digit, compare row, examine pattern
// - match and not 3: set, shift
// - pattern 3: no set, no shift
// - mismatch and not 3: shift only
// - 120 shifter hubs; punch uses 1-80
// - digit impulse presents hubs, row advances
// - five rewritable pattern tracks, numbered 1-5
// - one digit field selects the track
// - 0/1 pairs: numeric then zone, same hub
// - pattern 2: numeric digit, zone blank
// - write selects sign convention; sign at zone
// - pattern positions keep two low bits
// - 316 positions; data holds four bits
`timescale 1ns/1ps
module coe_top
   import coe_pkg::*;
(
   // clocks and reset
   input wire logic core_clk_i,
   input wire logic machine_clk_i,
   input wire logic rst_n_i,
   // processor command port
   input wire logic cmd_valid_i,
   input wire coe_cmd_t cmd_i,
   output logic cmd_ready_o,
   output logic unit_ready_o,
   output logic bad_track_o,
   // processor memory word fetch
   output logic mem_req_o,
   output logic [ADDR_W-1:0] mem_addr_o,
   input wire logic mem_ack_i,
   input wire logic [WORD_W-1:0] mem_data_i,
   // ready test and branch
   input wire logic rdy_test_valid_i,
   input wire logic [ADDR_W-1:0] rdy_test_addr_i,
   output coe_branch_t branch_o,
   // card machine link
   input wire logic digit_impulse_i,
   output logic [SHIFT_LEN-1:0] hub_o,
   output logic cycle_end_o
);
   // ******************************
   // resets
   // ******************************
   logic crst_n;
   logic lrst_n;

   coe_sync #(.W(1)) u_crst (
      .clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .d_i(1'b1),
      .q_o(crst_n)
   );

   coe_sync #(.W(1)) u_lrst (
      .clk_i(machine_clk_i),
      .rst_n_i(rst_n_i),
      .d_i(1'b1),
      .q_o(lrst_n)
   );

   // ******************************
   // track storage
   // ******************************
   // data track of full digits; five two-bit pattern tracks
   logic [3:0] data_mem [NUM_POS];
   logic [1:0] pat_mem [NUM_TRACKS][NUM_POS];

   // ******************************
   // core domain: processor to buffer
   // ******************************
   coe_cstate_t cstate_r;
   coe_op_t op_r;
   logic [2:0] trk_r;
   logic sup12_r;
   logic punch_r;
   logic [ADDR_W-1:0] addr_r;
   logic [WORD_W-1:0] word_r;
   logic [3:0] dig_idx_r;
   logic [4:0] word_cnt_r;
   logic words_done_r;
   logic [POS_W-1:0] pos_r;
   logic busy_r;
   logic ready_r;
   logic start_tgl_r;
   logic bad_r;
   logic done_s;
   logic done_seen_r;
   logic done_tgl_r;
   logic mem_req_r;
   coe_branch_t br_r;

   logic accept;
   logic track_ok;
   logic [2:0] trk_idx;
   logic [3:0] cur_dig;
   logic [1:0] cur_pat;
   logic consume;
   logic last_dig;
   logic fill_end;
   logic done_ev;

   // track digit 1..5 maps to index 0..4
   assign track_ok = (cmd_i.track >= TRACK_MIN) && (cmd_i.track <= TRACK_MAX);
   assign trk_idx = trk_r - TRACK_MIN;
   // writes and pattern loads wait until the unit is ready
   assign accept = cmd_valid_i && ready_r;
   assign cur_dig = words_done_r ? 4'h0 : word_r[dig_idx_r*4 +: 4];
   assign cur_pat = pat_mem[trk_idx][pos_r];
   // blank positions take an inserted zero and leave the word alone
   assign consume = (op_r == OP_PATLOAD) || (cur_pat != PAT_BLANK);
   assign last_dig = consume && (dig_idx_r == DIG_LAST) && !words_done_r;
   assign fill_end = (cstate_r == C_FILL) && (pos_r == POS_LAST);
   assign done_ev = done_s ^ done_seen_r;

   always_ff @(posedge core_clk_i or negedge crst_n) begin
      if (!crst_n) begin
         cstate_r <= C_IDLE;
         op_r <= OP_WRITE;
         trk_r <= TRACK_MIN;
         sup12_r <= 1'b0;
         punch_r <= 1'b0;
         addr_r <= '0;
         word_r <= '0;
         dig_idx_r <= 4'h0;
         word_cnt_r <= 5'h00;
         words_done_r <= 1'b0;
         pos_r <= '0;
         mem_req_r <= 1'b0;
         bad_r <= 1'b0;
      end else begin
         bad_r <= 1'b0;
         case (cstate_r)
            C_IDLE: begin
               if (accept && !track_ok) begin
                  bad_r <= 1'b1;
               end else if (accept) begin
                  op_r <= cmd_i.op;
                  trk_r <= cmd_i.track;
                  // sign convention carried with the write
                  sup12_r <= cmd_i.suppress12;
                  punch_r <= cmd_i.punch;
                  addr_r <= cmd_i.addr;
                  word_cnt_r <= 5'h00;
                  words_done_r <= 1'b0;
                  pos_r <= '0;
                  mem_req_r <= 1'b1;
                  cstate_r <= C_FETCH;
               end
            end
            C_FETCH: begin
               if (mem_ack_i) begin
                  word_r <= mem_data_i;
                  dig_idx_r <= 4'h0;
                  mem_req_r <= 1'b0;
                  cstate_r <= C_FILL;
               end
            end
            C_FILL: begin
               // one position per cycle, next word at the lower address
               pos_r <= pos_r + 9'h001;
               if (consume && !words_done_r) begin
                  dig_idx_r <= dig_idx_r + 4'h1;
               end
               if (fill_end) begin
                  cstate_r <= C_IDLE;
               end else if (last_dig && word_cnt_r == WORD_LAST) begin
                  words_done_r <= 1'b1;
               end else if (last_dig) begin
                  word_cnt_r <= word_cnt_r + 5'h01;
                  addr_r <= addr_r - 16'h0001;
                  mem_req_r <= 1'b1;
                  cstate_r <= C_FETCH;
               end
            end
            default: begin
               cstate_r <= C_IDLE;
            end
         endcase
      end
   end

   // no reset: contents are only meaningful once software loads them
   always_ff @(posedge core_clk_i) begin
      if (cstate_r == C_FILL && op_r == OP_PATLOAD) begin
         // high bits of a pattern digit are dropped
         pat_mem[trk_idx][pos_r] <= cur_dig[1:0];
      end
      if (cstate_r == C_FILL && op_r == OP_WRITE) begin
         // zero insert, digit otherwise stored as it arrives
         data_mem[pos_r] <= (cur_pat == PAT_BLANK) ? 4'h0 : cur_dig;
      end
   end

   // busy spans the machine transfer; a write cannot end while busy, so set and clear never meet
   always_ff @(posedge core_clk_i or negedge crst_n) begin
      if (!crst_n) begin
         busy_r <= 1'b0;
         start_tgl_r <= 1'b0;
         done_seen_r <= 1'b0;
         ready_r <= 1'b0;
      end else begin
         done_seen_r <= done_s;
         // a finished write hands the track to the machine side
         if (fill_end && op_r == OP_WRITE) begin
            busy_r <= 1'b1;
            start_tgl_r <= ~start_tgl_r;
         end else if (done_ev) begin
            busy_r <= 1'b0;
         end
         // ready only when idle and no transfer is pending
         ready_r <= (cstate_r == C_IDLE) && !busy_r && !accept && !fill_end;
      end
   end

   // branch answer one cycle after the test
   always_ff @(posedge core_clk_i or negedge crst_n) begin
      if (!crst_n) begin
         br_r <= '0;
      end else begin
         br_r.load <= rdy_test_valid_i && ready_r;
         br_r.next <= rdy_test_valid_i && !ready_r;
         if (rdy_test_valid_i) begin
            br_r.target <= rdy_test_addr_i;
         end
      end
   end

   coe_sync #(.W(1)) u_done_sync (
      .clk_i(core_clk_i),
      .rst_n_i(crst_n),
      .d_i(done_tgl_r),
      .q_o(done_s)
   );

   // ******************************
   // crossing into the machine domain
   // ******************************
   // config settles at accept, long before the start toggle flips
   logic start_s;
   logic start_seen_r;
   logic [4:0] cfg_s;
   logic start_ev;

   coe_sync #(.W(1)) u_start_sync (
      .clk_i(machine_clk_i),
      .rst_n_i(lrst_n),
      .d_i(start_tgl_r),
      .q_o(start_s)
   );

   coe_sync #(.W(5)) u_cfg_sync (
      .clk_i(machine_clk_i),
      .rst_n_i(lrst_n),
      .d_i({trk_idx, sup12_r, punch_r}),
      .q_o(cfg_s)
   );

   assign start_ev = start_s ^ start_seen_r;

   // ******************************
   // machine domain: buffer to card machine
   // ******************************
   coe_lstate_t lstate_r;
   logic [POS_W-1:0] scan_pos_r;
   logic [3:0] row_r;
   logic v1_r;
   logic [3:0] cmp_r;
   logic [1:0] lpat_r;
   logic phase_r;
   logic pend_r;
   logic imp_prev_r;
   logic end_r;
   logic [SHIFT_LEN-1:0] shifter_r;
   logic [SHIFT_LEN-1:0] hub_r;
   logic [SHIFT_LEN-1:0] hub_mask;

   logic imp_ev;
   logic row_clear;
   logic num_row;
   logic match_num;
   logic match_zone;

   assign imp_ev = digit_impulse_i && !imp_prev_r;
   assign row_clear = (lstate_r == L_IDLE && start_ev) ||
                      (lstate_r == L_WAIT && imp_ev && row_r != ROW_LAST);
   assign num_row = row_r <= ROW_NUM_END;
   assign match_num = num_row && (cmp_r == row_r);
   // minus takes the 11 row; plus takes the 12 row unless suppressed
   assign match_zone = ((row_r == ROW_ZONE_11) && (cmp_r == DIG_MINUS)) ||
                       ((row_r == ROW_ZONE_12) && (cmp_r == DIG_PLUS) && !cfg_s[1]);

   // punch leaves hubs 81 to 120 dark
   genvar gi;
   generate
      for (gi = 0; gi < SHIFT_LEN; gi++) begin : g_mask
         assign hub_mask[gi] = (gi < PUNCH_LEN) || !cfg_s[0];
      end
   endgenerate

   always_ff @(posedge machine_clk_i or negedge lrst_n) begin
      if (!lrst_n) begin
         lstate_r <= L_IDLE;
         scan_pos_r <= '0;
         row_r <= ROW_FIRST;
         start_seen_r <= 1'b0;
         imp_prev_r <= 1'b0;
         done_tgl_r <= 1'b0;
         end_r <= 1'b0;
         hub_r <= '0;
      end else begin
         start_seen_r <= start_s;
         imp_prev_r <= digit_impulse_i;
         end_r <= 1'b0;
         case (lstate_r)
            L_IDLE: begin
               if (start_ev) begin
                  // every card cycle starts at the first row
                  row_r <= ROW_FIRST;
                  scan_pos_r <= '0;
                  hub_r <= '0;
                  lstate_r <= L_SCAN;
               end
            end
            L_SCAN: begin
               scan_pos_r <= scan_pos_r + 9'h001;
               if (scan_pos_r == POS_LAST) begin
                  lstate_r <= L_DRAIN;
               end
            end
            L_DRAIN: begin
               lstate_r <= L_WAIT;
            end
            L_WAIT: begin
               // impulses before the scan is complete are ignored
               if (imp_ev) begin
                  // present set positions on the impulse
                  hub_r <= shifter_r & hub_mask;
                  scan_pos_r <= '0;
                  if (row_r == ROW_LAST) begin
                     // end of cycle tells the core side the card transfer is complete
                     done_tgl_r <= ~done_tgl_r;
                     end_r <= 1'b1;
                     lstate_r <= L_IDLE;
                  end else begin
                     row_r <= row_r + 4'h1;
                     lstate_r <= L_SCAN;
                  end
               end
            end
            default: begin
               lstate_r <= L_IDLE;
            end
         endcase
      end
   end

   // digit and pattern latched into the comparison stage
   always_ff @(posedge machine_clk_i or negedge lrst_n) begin
      if (!lrst_n) begin
         v1_r <= 1'b0;
         cmp_r <= 4'h0;
         lpat_r <= PAT_DELETE;
      end else begin
         v1_r <= (lstate_r == L_SCAN);
         if (lstate_r == L_SCAN) begin
            cmp_r <= data_mem[scan_pos_r];
            lpat_r <= pat_mem[cfg_s[4:2]][scan_pos_r];
         end
      end
   end

   // a 0/1 pair drives one hub: its first member is held until the second shifts
   always_ff @(posedge machine_clk_i or negedge lrst_n) begin
      if (!lrst_n) begin
         shifter_r <= '0;
         phase_r <= 1'b0;
         pend_r <= 1'b0;
      end else if (row_clear) begin
         shifter_r <= '0;
         phase_r <= 1'b0;
         pend_r <= 1'b0;
      end else if (v1_r) begin
         case (lpat_r)
            PAT_DELETE: begin
               // deleted digit neither sets nor shifts
               shifter_r <= shifter_r;
            end
            PAT_NUMERIC: begin
               // numeric only; zone rows never match here
               shifter_r <= {shifter_r[SHIFT_LEN-2:0], match_num};
            end
            default: begin
               // first of pair at numeric rows, second at zone rows
               if (!phase_r) begin
                  pend_r <= (lpat_r == PAT_ALPHA) && match_num;
                  phase_r <= 1'b1;
               end else begin
                  shifter_r <= {shifter_r[SHIFT_LEN-2:0],
                                pend_r || ((lpat_r == PAT_ALPHA) && match_zone)};
                  phase_r <= 1'b0;
               end
            end
         endcase
      end
   end

   // ******************************
   // outputs
   // ******************************
   assign cmd_ready_o = ready_r;
   assign unit_ready_o = ready_r;
   assign bad_track_o = bad_r;
   assign mem_req_o = mem_req_r;
   assign mem_addr_o = addr_r;
   assign branch_o = br_r;
   assign hub_o = hub_r;
   assign cycle_end_o = end_r;
endmodule : coe_top

// file: dv/coe_chk.sv
// port assertions for the card output edit buffer
`timescale 1ns/1ps
module coe_chk
   import coe_pkg::*;
(
   // clocks and reset
   input wire logic core_clk_i,
   input wire logic machine_clk_i,
   input wire logic rst_n_i,
   // core side
   input wire logic cmd_valid_i,
   input wire coe_cmd_t cmd_i,
   input wire logic cmd_ready_o,
   input wire logic unit_ready_o,
   input wire logic bad_track_o,
   input wire logic mem_req_o,
   input wire logic [ADDR_W-1:0] mem_addr_o,
   input wire logic mem_ack_i,
   input wire logic rdy_test_valid_i,
   input wire logic [ADDR_W-1:0] rdy_test_addr_i,
   input wire coe_branch_t branch_o,
   // link side
   input wire logic digit_impulse_i,
   input wire logic [SHIFT_LEN-1:0] hub_o,
   input wire logic cycle_end_o
);
   logic take;
   logic trk_ok;
   logic [ADDR_W-1:0] ack_addr_r;
   assign take = cmd_valid_i && cmd_ready_o;
   assign trk_ok = cmd_i.track >= TRACK_MIN && cmd_i.track <= TRACK_MAX;
   // last delivered word address, so each new fetch can be tied to it
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_addr_r <= '0;
      end else if (mem_req_o && mem_ack_i) begin
         ack_addr_r <= mem_addr_o;
      end
   end
   property p_ready_same;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         unit_ready_o == cmd_ready_o && !(mem_req_o && unit_ready_o);
   endproperty
   a_ready_same: assert property (p_ready_same) else $error("ready outputs differ");
   property p_take_fetch;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         take && trk_ok |=> mem_req_o && !cmd_ready_o && mem_addr_o == $past(cmd_i.addr);
   endproperty
   a_take_fetch: assert property (p_take_fetch) else $error("no fetch after take");
   property p_req_hold;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("fetch dropped early");
   property p_addr_down;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         $rose(mem_req_o) && !$past(cmd_ready_o) |-> mem_addr_o == ack_addr_r - 16'h0001;
   endproperty
   a_addr_down: assert property (p_addr_down) else $error("word address not descending");
   property p_bad_track;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         take && !trk_ok |=> !mem_req_o ##[0:1] bad_track_o;
   endproperty
   a_bad_track: assert property (p_bad_track) else $error("bad track not refused");
   property p_branch;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         rdy_test_valid_i |=> branch_o.load == $past(unit_ready_o)
            && branch_o.next == !$past(unit_ready_o) && branch_o.target == $past(rdy_test_addr_i);
   endproperty
   a_branch: assert property (p_branch) else $error("wrong branch answer");
   property p_no_branch;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         !rdy_test_valid_i |=> !branch_o.load && !branch_o.next;
   endproperty
   a_no_branch: assert property (p_no_branch) else $error("branch without test");
   property p_hub_step;
      @(posedge machine_clk_i) disable iff (!rst_n_i)
         $changed(hub_o) && hub_o != '0 |-> $past(digit_impulse_i) && !$past(digit_impulse_i, 2);
   endproperty
   a_hub_step: assert property (p_hub_step) else $error("hubs moved off impulse");
   property p_end_pulse;
      @(posedge machine_clk_i) disable iff (!rst_n_i) cycle_end_o |=> !cycle_end_o;
   endproperty
   a_end_pulse: assert property (p_end_pulse) else $error("cycle end too long");
   c_write: cover property (@(posedge core_clk_i) take && trk_ok && cmd_i.op == OP_WRITE);
   c_bad: cover property (@(posedge core_clk_i) take && !trk_ok);
   c_load: cover property (@(posedge core_clk_i) branch_o.load);
   c_end: cover property (@(posedge machine_clk_i) cycle_end_o);
endmodule : coe_chk

bind coe_top coe_chk u_coe_chk (.core_clk_i, .machine_clk_i, .rst_n_i, .cmd_valid_i, .cmd_i,
   .cmd_ready_o, .unit_ready_o, .bad_track_o, .mem_req_o, .mem_addr_o, .mem_ack_i,
   .rdy_test_valid_i, .rdy_test_addr_i, .branch_o, .digit_impulse_i, .hub_o, .cycle_end_o);

// file: dv/coe_machine.sv
// card machine model: link clock, digit impulses, hub capture per row
`timescale 1ns/1ps
module coe_machine
   import coe_pkg::*;
(
   // link
   output logic machine_clk_o,
   output logic digit_impulse_o,
   input wire logic [SHIFT_LEN-1:0] hub_i,
   input wire logic cycle_end_i,
   // captured rows of the last card cycle
   output logic [SHIFT_LEN-1:0] frame_o [12],
   output int frames_o
);
   logic [SHIFT_LEN-1:0] hist [12];
   initial begin
      machine_clk_o = 1'b0;
      digit_impulse_o = 1'b0;
      frames_o = 0;
   end
   // machine runs free: reset and the start handshake need link edges
   always #3 machine_clk_o = ~machine_clk_o;
   initial begin
      forever begin
         repeat (330) @(posedge machine_clk_o);
         digit_impulse_o <= 1'b1;
         repeat (3) @(posedge machine_clk_o);
         for (int i = 0; i < 11; i++) hist[i] = hist[i+1];
         hist[11] = hub_i;
         repeat (20) @(posedge machine_clk_o);
         digit_impulse_o <= 1'b0;
      end
   end
   // impulses ignored mid-scan also enter the history; the last twelve are the card
   always @(posedge machine_clk_o) begin
      if (cycle_end_i === 1'b1) begin
         repeat (4) @(posedge machine_clk_o);
         frame_o = hist;
         frames_o = frames_o + 1;
      end
   end
endmodule : coe_machine

// file: dv/tb_top.sv
// self-checking bench for the card output edit buffer
`timescale 1ns/1ps
module tb_top
   import coe_pkg::*;
;
   logic core_clk_i = 1'b0;
   logic machine_clk_i, rst_n_i, cmd_valid_i, mem_ack_i, rdy_test_valid_i, digit_impulse_i;
   logic cmd_ready_o, unit_ready_o, bad_track_o, mem_req_o, cycle_end_o;
   coe_cmd_t cmd_i;
   coe_branch_t branch_o;
   logic [WORD_W-1:0] mem_data_i;
   logic [ADDR_W-1:0] rdy_test_addr_i, mem_addr_o;
   logic [ADDR_W-1:0] base = 16'h0100;
   logic [SHIFT_LEN-1:0] hub_o;
   logic [SHIFT_LEN-1:0] frame [12];
   logic [WORD_W-1:0] mem [29];
   int frames, words, mismatches, samples_checked, q, nw;
   int pat [6][319];
   int dat [6][319];
   bit sup [6];
   bit pch [6];
   coe_top u_coe_top (.core_clk_i, .machine_clk_i, .rst_n_i, .cmd_valid_i, .cmd_i, .cmd_ready_o,
      .unit_ready_o, .bad_track_o, .mem_req_o, .mem_addr_o, .mem_ack_i, .mem_data_i,
      .rdy_test_valid_i, .rdy_test_addr_i, .branch_o, .digit_impulse_i, .hub_o, .cycle_end_o);
   coe_machine u_coe_machine (.machine_clk_o(machine_clk_i), .digit_impulse_o(digit_impulse_i),
      .hub_i(hub_o), .cycle_end_i(cycle_end_o), .frame_o(frame), .frames_o(frames));
   always #25 core_clk_i = ~core_clk_i;
   task automatic chk(input string n, input logic [SHIFT_LEN-1:0] e, g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic conclude();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude
   // memory answers after a random wait; between answers the data lines scramble
   always @(negedge core_clk_i) begin
      logic a;
      a = mem_req_o === 1'b1 && $urandom_range(2) == 0;
      mem_data_i = a ? mem[(base - mem_addr_o) % 29] : ~mem_data_i;
      if (a) begin
         chk("word address", 1, base - mem_addr_o < 29);
         words++;
      end
      mem_ack_i = a;
   end
   task automatic send(input coe_op_t op, input int t, input bit s, input bit p);
      cmd_i = '{op: op, track: 3'(t), suppress12: s, punch: p, addr: base};
      words = 0;
      cmd_valid_i = 1'b1;
      for (int i = 0; i < 40000 && cmd_ready_o !== 1'b1; i++) @(negedge core_clk_i);
      @(negedge core_clk_i);
      cmd_valid_i = 1'b0;
      for (int i = 0; i < 2000 && (words < nw && t inside {[1:5]}); i++) @(negedge core_clk_i);
      repeat (20) @(negedge core_clk_i);
   endtask : send
   task automatic rtest(input bit exp);
      rdy_test_addr_i = 16'($urandom);
      rdy_test_valid_i = 1'b1;
      @(negedge core_clk_i);
      rdy_test_valid_i = 1'b0;
      chk("branch load", exp, branch_o.load);
      chk("branch next", !exp, branch_o.next);
      chk("branch target", rdy_test_addr_i, branch_o.target);
   endtask : rtest
   task automatic gen(input int t);
      int p, k;
      p = 0;
      while (p < NUM_POS) begin
         k = t == 1 ? (p < 120 ? 2 : 3) : $urandom_range(3);
         pat[t][p] = k;
         // a 2 never lands on the zone member of a pair
         if (k < 2 && p < NUM_POS - 1) begin
            p++;
            pat[t][p] = $urandom_range(1);
         end else if (k < 2) begin
            pat[t][p] = 2;
         end
         p++;
      end
   endtask : gen
   function automatic logic [SHIFT_LEN-1:0] exp_row(input int r, input int t);
      logic [SHIFT_LEN-1:0] sh;
      logic m;
      int p;
      sh = '0;
      p = 0;
      while (p < NUM_POS) begin
         m = r < 10 && dat[t][p] == r && pat[t][p] != 0;
         if (pat[t][p] < 2 && r == 10) m = pat[t][p+1] == 1 && dat[t][p+1] == 1;
         if (pat[t][p] < 2 && r == 11) m = pat[t][p+1] == 1 && dat[t][p+1] == 0 && !sup[t];
         if (pat[t][p] != 3) sh = {sh[SHIFT_LEN-2:0], m};
         p += pat[t][p] < 2 ? 2 : 1;
      end
      if (pch[t]) sh[SHIFT_LEN-1:PUNCH_LEN] = '0;
      return sh;
   endfunction : exp_row
   task automatic check_frame(input int t);
      for (int r = 0; r < 12; r++) begin
         chk($sformatf("card %0d row %0d", t, r), exp_row(r, t), frame[r]);
      end
   endtask : check_frame
   initial begin
      #3_000_000;
      mismatches++;
      conclude();
   end
   // ******************************
   // main sequence
   // ******************************
   initial begin
      void'($urandom(32'h04de2e5a));
      {cmd_valid_i, rdy_test_valid_i, rst_n_i} = '0;
      {cmd_i, rdy_test_addr_i} = '0;
      nw = 29;
      repeat (16) @(negedge core_clk_i);
      chk("ready in reset", 0, cmd_ready_o);
      rst_n_i = 1'b1;
      repeat (5) @(negedge core_clk_i);
      rtest(1'b1);
      for (int t = 1; t <= 5; t++) begin
         gen(t);
         for (int p = 0; p < 319; p++) begin
            mem[p/11][4*(p%11)+:4] = {2'($urandom), 2'(p < NUM_POS ? pat[t][p] : 3)};
         end
         send(OP_PATLOAD, t, 1'b0, 1'b0);
         chk("load words", 29, words);
      end
      for (int i = 0; i < 3; i++) begin
         send(OP_WRITE, i == 0 ? 0 : 5 + i, 1'b0, 1'b0);
         chk("bad track words", 0, words);
         chk("bad track ready", 1, unit_ready_o);
      end
      for (int t = 1; t <= 5; t++) begin
         for (int p = 0; p < 319; p++) begin
            mem[p/11][4*(p%11)+:4] = 4'($urandom_range(9));
         end
         // a 0 position stores 0 and takes no source digit
         q = 0;
         for (int p = 0; p < NUM_POS; p++) begin
            dat[t][p] = pat[t][p] == 0 ? 0 : mem[q/11][4*(q%11)+:4];
            if (pat[t][p] != 0) q++;
            // the last position never asks for another word
            if (p == NUM_POS - 2) nw = q / 11 + 1;
         end
         sup[t] = $urandom_range(1);
         pch[t] = t == 5;
         if (t > 1) chk("busy before write", t - 2, frames);
         send(OP_WRITE, t, sup[t], pch[t]);
         chk("stalled until done", t - 1, frames);
         chk("write words", nw, words);
         rtest(1'b0);
         if (t > 1) check_frame(t - 1);
      end
      for (int i = 0; i < 20000 && frames < 5; i++) @(negedge core_clk_i);
      check_frame(5);
      conclude();
   end
endmodule : tb_top
